//--- logic/ptp_port_timestamp_irq.sv
// Per-port egress timestamp flags, enables, link delay and sync time.
// Assumes capture pulses from the timestamp datapath, synchronous to ref_clk.
//
// The placing of the registers and the Wishbone register port were decided locally.

module ptp_port_timestamp_irq
  import ptp_stamp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire capture_s capture,
  input wire wb_req_s wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic irq,
  output logic summaryStatus,
  output logic summaryEnable
);

  state_s state_reg;
  state_s state_next;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  function automatic logic [2:0] pick_class(input logic [31:0] w);
    return {w[SYNC_BIT], w[DELAY_REQ_BIT], w[PDELAY_RESP_BIT]};
  endfunction : pick_class

  function automatic logic [31:0] place_class(input logic [2:0] c);
    logic [31:0] w;
    w = 32'h00000000;
    w[SYNC_BIT] = c[2];
    w[DELAY_REQ_BIT] = c[1];
    w[PDELAY_RESP_BIT] = c[0];
    return w;
  endfunction : place_class

  logic access;
  logic wrStrobe;
  logic [31:0] wrWord;
  logic [2:0] events;

  always_comb begin
    // Ack toggles off after one cycle so each request sees exactly one ack
    access = wbReq.cyc && wbReq.stb && !state_reg.ack;
    wrStrobe = access && wbReq.we;
    wrWord = lane_merge(32'h00000000, wbReq.dat, wbReq.sel);
    events = {capture.syncDone, capture.delayReqDone, capture.pdelayRespDone};
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.ack = access;
    state_next.rdata = 32'h00000000;

    if (wrStrobe && wbReq.adr == STATUS_OFFSET) begin
      state_next.flags = state_reg.flags & ~pick_class(wrWord);
    end
    state_next.flags = state_next.flags | events;

    if (wrStrobe && wbReq.adr == ENABLE_OFFSET) begin
      state_next.allow = pick_class(lane_merge(place_class(state_reg.allow), wbReq.dat, wbReq.sel));
    end
    if (wrStrobe && wbReq.adr == IRQ_MASK_OFFSET) begin
      state_next.mask = pick_class(lane_merge(place_class(state_reg.mask), wbReq.dat, wbReq.sel));
    end
    if (wrStrobe && wbReq.adr == LINK_DELAY_OFFSET) begin
      state_next.linkDelay = lane_merge(state_reg.linkDelay, wbReq.dat, wbReq.sel);
    end
    if (capture.syncDone) begin
      state_next.syncTime = capture.syncTime;
    end

    if (access && !wbReq.we) begin
      case (wbReq.adr)
        STATUS_OFFSET: state_next.rdata = place_class(state_reg.flags);
        ENABLE_OFFSET: state_next.rdata = place_class(state_reg.allow);
        LINK_DELAY_OFFSET: state_next.rdata = state_reg.linkDelay;
        SYNC_TIME_OFFSET: state_next.rdata = state_reg.syncTime;
        PORT_SUMMARY_OFFSET: begin
          state_next.rdata[SUMMARY_STATUS_BIT] = state_reg.summaryStatus;
          state_next.rdata[SUMMARY_ENABLE_BIT] = state_reg.summaryEnable;
        end
        IRQ_MASK_OFFSET: state_next.rdata = place_class(state_reg.mask);
        // Unmapped addresses read zero and still ack, so the bus never hangs
        default: state_next.rdata = 32'h00000000;
      endcase
    end

    state_next.summaryStatus = |state_next.flags;
    state_next.summaryEnable = |state_next.allow;
    // Class enables and the mask both gate the line
    state_next.irq = |(state_next.flags & state_next.allow & state_next.mask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.flags <= FLAGS_RESET;
      state_reg.allow <= ALLOW_RESET;
      state_reg.mask <= MASK_RESET;
      state_reg.linkDelay <= LINK_DELAY_RESET;
      state_reg.syncTime <= SYNC_TIME_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wbDatO = state_reg.rdata;
  assign wbAck = state_reg.ack;
  assign irq = state_reg.irq;
  assign summaryStatus = state_reg.summaryStatus;
  assign summaryEnable = state_reg.summaryEnable;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sync_set;
    @(posedge ref_clk) disable iff (reset) capture.syncDone |=> state_reg.flags[2];
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync flag not set");

  property p_dreq_set;
    @(posedge ref_clk) disable iff (reset) capture.delayReqDone |=> state_reg.flags[1];
  endproperty
  a_dreq_set: assert property (p_dreq_set) else $error("delay request flag not set");

  property p_resp_set;
    @(posedge ref_clk) disable iff (reset) capture.pdelayRespDone |=> state_reg.flags[0];
  endproperty
  a_resp_set: assert property (p_resp_set) else $error("response flag not set");

  property p_summary;
    @(posedge ref_clk) disable iff (reset) summaryStatus == (|state_reg.flags);
  endproperty
  a_summary: assert property (p_summary) else $error("summary status mismatch");

  property p_enable_write;
    @(posedge ref_clk) disable iff (reset)
      wrStrobe && wbReq.adr == ENABLE_OFFSET && wbReq.sel[1] |=> state_reg.allow[2] == $past(wbReq.dat[SYNC_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_summary_en;
    @(posedge ref_clk) disable iff (reset) summaryEnable == (|state_reg.allow);
  endproperty
  a_summary_en: assert property (p_summary_en) else $error("summary enable mismatch");

  property p_delay_hold;
    @(posedge ref_clk) disable iff (reset)
      !(wrStrobe && wbReq.adr == LINK_DELAY_OFFSET) |=> $stable(state_reg.linkDelay);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("link delay changed");

  property p_sync_time;
    @(posedge ref_clk) disable iff (reset) capture.syncDone |=> state_reg.syncTime == $past(capture.syncTime);
  endproperty
  a_sync_time: assert property (p_sync_time) else $error("sync time not latched");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (reset)
      state_reg.flags[2] && !(wrStrobe && wbReq.adr == STATUS_OFFSET) |=> state_reg.flags[2];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_ack_once;
    @(posedge ref_clk) disable iff (reset) wbAck |=> !wbAck;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  // ----------------------------------------
  // Flag and register checks
  // ----------------------------------------
  property p_summary_rise;
    @(posedge ref_clk) disable iff (reset)
      (|events) |=> summaryStatus;
  endproperty
  a_summary_rise: assert property (p_summary_rise) else $error("summary status late");

  property p_sync_clear;
    @(posedge ref_clk) disable iff (reset)
      wrStrobe && wbReq.adr == STATUS_OFFSET && wrWord[SYNC_BIT] && !capture.syncDone
      |=> !state_reg.flags[2];
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync flag not cleared");

  property p_dreq_clear;
    @(posedge ref_clk) disable iff (reset)
      wrStrobe && wbReq.adr == STATUS_OFFSET && wrWord[DELAY_REQ_BIT] && !capture.delayReqDone
      |=> !state_reg.flags[1];
  endproperty
  a_dreq_clear: assert property (p_dreq_clear) else $error("delay request flag not cleared");

  property p_resp_clear;
    @(posedge ref_clk) disable iff (reset)
      wrStrobe && wbReq.adr == STATUS_OFFSET && wrWord[PDELAY_RESP_BIT] && !capture.pdelayRespDone
      |=> !state_reg.flags[0];
  endproperty
  a_resp_clear: assert property (p_resp_clear) else $error("response flag not cleared");

  property p_no_spurious;
    @(posedge ref_clk) disable iff (reset)
      !(|events) |=> (state_reg.flags & ~$past(state_reg.flags)) == 3'h0;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without event");

  property p_all_sticky;
    @(posedge ref_clk) disable iff (reset)
      !(wrStrobe && wbReq.adr == STATUS_OFFSET)
      |=> (state_reg.flags & $past(state_reg.flags)) == $past(state_reg.flags);
  endproperty
  a_all_sticky: assert property (p_all_sticky) else $error("flag dropped without clear");

  property p_allow_hold;
    @(posedge ref_clk) disable iff (reset)
      !(wrStrobe && wbReq.adr == ENABLE_OFFSET) |=> $stable(state_reg.allow);
  endproperty
  a_allow_hold: assert property (p_allow_hold) else $error("enable changed without write");

  property p_delay_write;
    @(posedge ref_clk) disable iff (reset)
      wrStrobe && wbReq.adr == LINK_DELAY_OFFSET && wbReq.sel == 4'hf
      |=> state_reg.linkDelay == $past(wbReq.dat);
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("link delay write lost");

  property p_sync_time_hold;
    @(posedge ref_clk) disable iff (reset)
      !capture.syncDone |=> $stable(state_reg.syncTime);
  endproperty
  a_sync_time_hold: assert property (p_sync_time_hold) else $error("sync time changed");

  property p_summary_en_rise;
    @(posedge ref_clk) disable iff (reset)
      wrStrobe && wbReq.adr == ENABLE_OFFSET && wbReq.sel[1] && wbReq.dat[SYNC_BIT] |=> summaryEnable;
  endproperty
  a_summary_en_rise: assert property (p_summary_en_rise) else $error("summary enable late");

  property p_irq_needs_both;
    @(posedge ref_clk) disable iff (reset)
      irq |-> summaryStatus && summaryEnable;
  endproperty
  a_irq_needs_both: assert property (p_irq_needs_both) else $error("irq without flag and enable");

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  // Registered ack costs a cycle but keeps every output straight from a flop
  property p_ack_answer;
    @(posedge ref_clk) disable iff (reset)
      access |=> wbAck;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked");

  property p_ack_idle;
    @(posedge ref_clk) disable iff (reset)
      !access |=> !wbAck;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (reset)
      !wbAck |-> wbDatO == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");

  property p_status_read;
    @(posedge ref_clk) disable iff (reset)
      access && !wbReq.we && wbReq.adr == STATUS_OFFSET
      |=> wbDatO[SYNC_BIT] == $past(state_reg.flags[2]) && wbDatO[12:0] == 13'h0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_enable_read;
    @(posedge ref_clk) disable iff (reset)
      access && !wbReq.we && wbReq.adr == ENABLE_OFFSET
      |=> wbDatO[DELAY_REQ_BIT] == $past(state_reg.allow[1]) && wbDatO[31:16] == 16'h0;
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable readback wrong");

endmodule : ptp_port_timestamp_irq

//--- logic/ptp_stamp_pkg.sv
// Package for the per-port egress timestamp interrupt block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package ptp_stamp_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] STATUS_OFFSET = 8'h14;
  localparam logic [7:0] ENABLE_OFFSET = 8'h16;
  localparam logic [7:0] LINK_DELAY_OFFSET = 8'h18;
  localparam logic [7:0] SYNC_TIME_OFFSET = 8'h0c;
  localparam logic [7:0] PORT_SUMMARY_OFFSET = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h24;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SYNC_BIT = 15;
  localparam int DELAY_REQ_BIT = 14;
  localparam int PDELAY_RESP_BIT = 13;
  localparam int SUMMARY_STATUS_BIT = 0;
  localparam int SUMMARY_ENABLE_BIT = 1;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [2:0] ALLOW_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [31:0] LINK_DELAY_RESET = 32'h00000000;
  localparam logic [31:0] SYNC_TIME_RESET = 32'h00000000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic syncDone;
    logic delayReqDone;
    logic pdelayRespDone;
    logic [31:0] syncTime;
  } capture_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic [2:0] flags;
    logic [2:0] allow;
    logic [2:0] mask;
    logic [31:0] linkDelay;
    logic [31:0] syncTime;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic summaryStatus;
    logic summaryEnable;
  } state_s;

endpackage : ptp_stamp_pkg

//--- testbench/tb.sv
// Self-checking bench for the per-port timestamp interrupt block.
// Assumes one 20 MHz clock; the bench is the Wishbone master and capture source.
module tb
  import ptp_stamp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------
  // Signals and table
  // ------------------------------
  logic ref_clk;
  logic reset;
  capture_s capture;
  wb_req_s wbReq;
  logic [31:0] wbDatO;
  logic wbAck;
  logic irq;
  logic summaryStatus;
  logic summaryEnable;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] q;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;
  // Reserved enable bits 12:0 are written as ones and must read back zero
  row_s rows [0:15] = '{
    '{1'b0, 8'h14, 32'h0, 32'h0}, '{1'b0, 8'h16, 32'h0, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'h0},
    '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h18, 32'ha5a5_0f0f, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'ha5a5_0f0f}, '{1'b1, 8'h18, 32'hffff_ffff, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'hffff_ffff}, '{1'b1, 8'h16, 32'h0000_ffff, 32'h0},
    '{1'b0, 8'h16, 32'h0, 32'h0000_e000}, '{1'b0, 8'h20, 32'h0, 32'h2},
    '{1'b1, 8'h24, 32'h0000_e000, 32'h0}, '{1'b1, 8'h14, 32'h0000_ffff, 32'h0},
    '{1'b0, 8'h14, 32'h0, 32'h0}, '{1'b0, 8'h30, 32'h0, 32'h0}};

  ptp_port_timestamp_irq dut (.ref_clk(ref_clk), .reset(reset), .capture(capture), .wbReq(wbReq),
    .wbDatO(wbDatO), .wbAck(wbAck), .irq(irq), .summaryStatus(summaryStatus), .summaryEnable(summaryEnable));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Holds the request until ack is sampled, so no retake can occur
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk) wbReq <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    q = wbDatO;
    wbReq <= '0;
  endtask : wb

  task automatic pulse(input logic [2:0] k, input logic [31:0] t);
    @(posedge ref_clk) capture <= '{k[2], k[1], k[0], t};
    @(posedge ref_clk) capture <= '0;
    @(posedge ref_clk);
  endtask : pulse

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    reset = 1'b1;
    capture = '0;
    wbReq = '0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    check("outputs", {29'h0, irq, summaryStatus, summaryEnable}, 32'h0);
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check("row read", q, rows[i].e);
    end
    check("summaryEnable", {31'h0, summaryEnable}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      pulse(3'b100 >> i, 32'h8765_4321 + i);
      check("irq", {31'h0, irq}, 32'h1);
      check("summaryStatus", {31'h0, summaryStatus}, 32'h1);
      wb(1'b1, 8'h14, 32'h0);
      wb(1'b0, 8'h14, 32'h0);
      check("status", q, 32'h8000 >> i);
      wb(1'b1, 8'h14, 32'h8000 >> i);
      wb(1'b0, 8'h14, 32'h0);
      check("status", q, 32'h0);
      check("summaryStatus", {31'h0, summaryStatus}, 32'h0);
    end
    wb(1'b0, 8'h0c, 32'h0);
    check("syncTime", q, 32'h8765_4321);
    wb(1'b1, 8'h16, 32'h0);
    check("summaryEnable", {31'h0, summaryEnable}, 32'h0);
    pulse(3'b001, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    // Clear and capture on the same edge: the capture must win
    fork
      wb(1'b1, 8'h14, 32'h2000);
      pulse(3'b001, 32'h0);
    join
    wb(1'b0, 8'h14, 32'h0);
    check("status", q, 32'h2000);
    @(posedge ref_clk) reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    wb(1'b0, 8'h18, 32'h0);
    check("linkDelay", q, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    check("status", q, 32'h0);
    check("outputs", {29'h0, irq, summaryStatus, summaryEnable}, 32'h0);
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
endmodule : tb
